//--- hw/prog_read_pkg.sv
// Constants for the program memory read block
package prog_read_pkg;
   localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
   localparam logic [3:0]  ADDR_DATA_LOW  = 4'h4;
   localparam logic [3:0]  ADDR_DATA_HIGH = 4'h8;
   localparam logic [3:0]  ADDR_ADR_LOW   = 4'hc;
   localparam logic [3:0]  ADDR_ADR_HIGH  = 4'h0;
   localparam logic [4:0]  ADDR_ADR_HIGH5 = 5'h10;
   localparam int          READ_GO_BIT    = 0;
   localparam logic [7:0]  CONTROL_FIXED  = 8'h80;
   localparam int          WORD_WIDTH     = 14;
   localparam int          ADDR_WIDTH     = 13;
   localparam int          HIGH_ADR_BITS  = 5;
   localparam int          HIGH_DATA_BITS = 6;
   localparam int          CYCLES_PER_INSTR = 4;
   localparam int          READ_INSTRS    = 2;
   localparam logic [3:0]  READ_CYCLES    = 4'(CYCLES_PER_INSTR * READ_INSTRS);
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [7:0]  REG_RESET      = 8'h00;
endpackage : prog_read_pkg

//--- hw/program_memory_read.sv
// Program memory read block with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
module program_memory_read
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic [12:0] flash_addr,
   output var  logic        flash_read,
   input  wire logic [13:0] flash_data,
   output var  logic        instr_ignore
);
   typedef enum {IDLE, BUSY} read_state_e;

   read_state_e  state;
   read_state_e  next_state;
   logic [3:0]   count;
   logic [3:0]   next_count;
   logic [4:0]   adr_high;
   logic [4:0]   next_adr_high;
   logic [7:0]   adr_low;
   logic [7:0]   next_adr_low;
   logic [5:0]   data_high;
   logic [5:0]   next_data_high;
   logic [7:0]   data_low;
   logic [7:0]   next_data_low;
   logic         next_flash_read;
   logic         next_ignore;
   logic [12:0]  next_flash_addr;

   // Write channel state
   logic         aw_held;
   logic         next_aw_held;
   logic [4:0]   aw_addr;
   logic [4:0]   next_aw_addr;
   logic         w_held;
   logic         next_w_held;
   logic [31:0]  w_data;
   logic [31:0]  next_w_data;
   logic [3:0]   w_strb;
   logic [3:0]   next_w_strb;
   logic         next_awready;
   logic         next_wready;
   logic         next_bvalid;
   logic [1:0]   next_bresp;
   logic         next_arready;
   logic         next_rvalid;
   logic [31:0]  next_rdata;
   logic [1:0]   next_rresp;
   logic         do_write;
   logic         start;
   logic         busy;
   logic [7:0]   control_view;

   assign busy = (state == BUSY);
   assign control_view = prog_read_pkg::CONTROL_FIXED | {7'h00, busy};

   // Bus write handling
   always_comb
   begin
      next_aw_held  = aw_held;
      next_aw_addr  = aw_addr;
      next_w_held   = w_held;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bvalid   = s_axi_bvalid;
      next_bresp    = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (aw_addr[1:0] != 2'h0 || aw_addr > prog_read_pkg::ADDR_ADR_HIGH5) ?
                        prog_read_pkg::RESP_SLVERR : prog_read_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         next_bvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held       <= 1'b0;
         aw_addr       <= 5'h00;
         w_held        <= 1'b0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
      end
   end

   // Read engine and registers; no protection gate on the path
   always_comb
   begin
      next_state      = state;
      next_count      = count;
      next_adr_high   = adr_high;
      next_adr_low    = adr_low;
      next_data_high  = data_high;
      next_data_low   = data_low;
      next_flash_read = 1'b0;
      next_ignore     = busy;
      next_flash_addr = flash_addr;
      start = do_write && w_strb[0] && (aw_addr[3:0] == prog_read_pkg::ADDR_CONTROL) && !aw_addr[4]
              && w_data[prog_read_pkg::READ_GO_BIT];
      if (do_write && w_strb[0] && !busy)
      begin
         if (aw_addr == prog_read_pkg::ADDR_ADR_HIGH5)
            next_adr_high = w_data[4:0];
         if (aw_addr == {1'b0, prog_read_pkg::ADDR_ADR_LOW})
            next_adr_low = w_data[7:0];
         if (aw_addr == {1'b0, prog_read_pkg::ADDR_DATA_LOW})
            next_data_low = w_data[7:0];
         if (aw_addr == {1'b0, prog_read_pkg::ADDR_DATA_HIGH})
            next_data_high = w_data[5:0];
      end
      case (state)
         IDLE:
         begin
            if (start)
            begin
               next_state      = BUSY;
               next_count      = prog_read_pkg::READ_CYCLES - 4'h1;
               next_flash_read = 1'b1;
               next_ignore     = 1'b1;
               next_flash_addr = {adr_high, adr_low};
            end
         end
         BUSY:
         begin
            next_ignore = 1'b1;
            if (count == 4'h0)
            begin
               next_state     = IDLE;
               next_ignore    = 1'b0;
               next_data_low  = flash_data[7:0];
               next_data_high = flash_data[13:8];
            end
            else
               next_count = count - 4'h1;
         end
         default:
            next_state = IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= IDLE;
         count        <= 4'h0;
         adr_high     <= 5'h00;
         adr_low      <= 8'h00;
         data_high    <= 6'h00;
         data_low     <= 8'h00;
         flash_read   <= 1'b0;
         instr_ignore <= 1'b0;
         flash_addr   <= 13'h0000;
      end
      else
      begin
         state        <= next_state;
         count        <= next_count;
         adr_high     <= next_adr_high;
         adr_low      <= next_adr_low;
         data_high    <= next_data_high;
         data_low     <= next_data_low;
         flash_read   <= next_flash_read;
         instr_ignore <= next_ignore;
         flash_addr   <= next_flash_addr;
      end
   end

   // Bus read handling
   always_comb
   begin
      next_arready = 1'b0;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
         next_arready = 1'b1;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = prog_read_pkg::RESP_OKAY;
         case (s_axi_araddr)
            {1'b0, prog_read_pkg::ADDR_CONTROL}:   next_rdata = {24'h000000, control_view};
            {1'b0, prog_read_pkg::ADDR_DATA_LOW}:  next_rdata = {24'h000000, data_low};
            {1'b0, prog_read_pkg::ADDR_DATA_HIGH}: next_rdata = {26'h0000000, data_high};
            {1'b0, prog_read_pkg::ADDR_ADR_LOW}:   next_rdata = {24'h000000, adr_low};
            prog_read_pkg::ADDR_ADR_HIGH5:        next_rdata = {27'h0000000, adr_high};
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = prog_read_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // Checks
   sequence read_started;
      flash_read;
   endsequence

   sequence read_finished;
      ##7 (state == BUSY && count == 4'h0) ##1 (state == IDLE);
   endsequence

   chk_read_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
      read_started |-> read_finished)
      else $error("read did not last eight cycles");

   chk_ignore_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
      flash_read |-> instr_ignore [*8])
      else $error("ignore window too short");

   chk_go_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == BUSY && count == 4'h0) |=> !busy && !control_view[0])
      else $error("read-go not cleared");

   chk_data_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == BUSY && count == 4'h0) |=> data_low == $past(flash_data[7:0])
      && data_high == $past(flash_data[13:8]))
      else $error("fetched word not loaded");

   chk_addr_used: assert property (@(posedge sys_clk) disable iff (!rst_n)
      flash_read |-> flash_addr == {adr_high, adr_low})
      else $error("wrong read address");

   chk_busy_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (busy && count != 4'h0) |=> $stable(adr_high) && $stable(adr_low) && $stable(data_low)
      && $stable(data_high))
      else $error("registers changed during read");

   chk_zero_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!busy && !start) |=> !flash_read)
      else $error("read started without set");

   chk_control_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == {1'b0, prog_read_pkg::ADDR_CONTROL})
      |=> s_axi_rdata[31:1] == 31'h00000040)
      else $error("control fixed bits wrong");
endmodule // program_memory_read
`default_nettype wire

//--- tb/flash_model.sv
// Flash array model answering the block's read pulse
`timescale 1ns/10ps
`default_nettype none
module flash_model
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [12:0] flash_addr,
   input  wire logic        flash_read,
   output var  logic [13:0] flash_data
);
   logic [3:0]  cnt;
   logic [12:0] adr;
   logic [13:0] junk;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt  <= 4'h0;
         adr  <= 13'h0000;
         junk <= 14'h1555;
      end
      else
      begin
         junk <= ~junk;
         if (flash_read)
         begin
            cnt <= 4'hb;
            adr <= flash_addr;
         end
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
      end
   end
   // No protection gate; outside the read window the line toggles
   always_comb
      flash_data = (cnt != 4'h0) ? ({adr[4:0], adr[12:4]} ^ 14'h2a5c) : junk;
endmodule // flash_model
`default_nettype wire

//--- tb/tb_top.sv
// Testbench for the program memory read block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  s_axi_awaddr = 5'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [4:0]  s_axi_araddr = 5'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic [12:0] flash_addr;
   logic        flash_read;
   logic [13:0] flash_data;
   logic        instr_ignore;
   logic [12:0] pulse_addr = 13'h0;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          n_pulse = 0;
   int          n_ign = 0;
   localparam logic [1:0] OK = prog_read_pkg::RESP_OKAY;
   localparam logic [1:0] ER = prog_read_pkg::RESP_SLVERR;
   always #20 sys_clk = ~sys_clk;
   program_memory_read u_dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_read, .flash_data, .instr_ignore);
   flash_model u_flash (.sys_clk, .rst_n, .flash_addr, .flash_read, .flash_data);
   function automatic logic [13:0] exp_word(input logic [12:0] a);
      return {a[4:0], a[12:4]} ^ 14'h2a5c;
   endfunction
   task automatic final_report();
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
      chk_word({30'h0, e}, {30'h0, g});
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      chk_resp(er, s_axi_bresp);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      chk_resp(er, s_axi_rresp);
      if (er === OK)
         chk_word(e, s_axi_rdata);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Start a fetch; optionally disturb the address while busy
   task automatic do_read(input logic [12:0] a, input bit bw);
      int p;
      p = n_pulse;
      wr(5'h0c, {24'h0, a[7:0]}, OK);
      wr(5'h10, {27'h0, a[12:8]}, OK);
      n_ign = 0;
      wr(5'h00, 32'h1, OK);
      if (bw)
      begin
         wr(5'h0c, {24'h0, ~a[7:0]}, OK);
         wr(5'h00, 32'h1, OK);
      end
      else
         rd(5'h00, 32'h81, OK);
      // Bus idle while the two instructions are ignored
      for (int i = 0; i < 40 && instr_ignore !== 1'b0; i++)
         @(posedge sys_clk);
      @(posedge sys_clk);
      chk_word(32'(prog_read_pkg::READ_CYCLES), 32'(n_ign));
      chk_word(32'(p + 1), 32'(n_pulse));
      chk_word({19'h0, a}, {19'h0, pulse_addr});
      rd(5'h04, {24'h0, exp_word(a)[7:0]}, OK);
      rd(5'h08, {26'h0, exp_word(a)[13:8]}, OK);
      rd(5'h0c, {24'h0, a[7:0]}, OK);
      rd(5'h00, 32'h80, OK);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (instr_ignore === 1'b1)
         n_ign++;
      if (flash_read === 1'b1)
      begin
         n_pulse++;
         pulse_addr = flash_addr;
      end
      if (cyc == 4000)
      begin
         n_errors++;
         final_report();
      end
   end
   initial
   begin
      int unsigned s;
      s = $urandom(45627);
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(5'h00, 32'h80, OK);
      rd(5'h08, 32'h0, OK);
      wr(5'h10, 32'hff, OK);
      rd(5'h10, 32'h1f, OK);
      wr(5'h00, 32'hfe, OK);
      repeat (3) @(posedge sys_clk);
      chk_word(32'h0, 32'(n_pulse));
      rd(5'h00, 32'h80, OK);
      // Byte lane 0 off: neither a start nor a store may happen
      s_axi_wstrb <= 4'he;
      wr(5'h00, 32'h1, OK);
      wr(5'h0c, 32'h55, OK);
      s_axi_wstrb <= 4'hf;
      chk_word(32'h0, 32'(n_pulse));
      rd(5'h0c, 32'h0, OK);
      wr(5'h14, 32'h1, ER);
      rd(5'h02, 32'h0, ER);
      do_read(13'h1fff, 1'b0);
      do_read(13'h0000, 1'b0);
      do_read(13'h0a5a, 1'b1);
      repeat (8)
         do_read(13'($urandom), 1'b0);
      // Reset in the middle of a fetch, then a clean fetch again
      wr(5'h00, 32'h1, OK);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(5'h00, 32'h80, OK);
      rd(5'h04, 32'h0, OK);
      do_read(13'h1234, 1'b0);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
